/* verilog/vectored_interrupt_sequencer.sv */
`timescale 1ns/1ps
`default_nettype none
`include "vectored_interrupt_sequencer_defines.svh"
module vectored_interrupt_sequencer (
  input  wire logic                                  clk_sys_i,    // Clock.
  input  wire logic                                  arst_n_i,     // Reset.
  input  wire logic [7:0]                            reg_addr_i,   // Reg addr.
  input  wire logic                                  reg_wr_i,     // Write.
  input  wire logic                                  reg_rd_i,     // Read.
  input  wire vectored_interrupt_sequencer_pkg::byte_t reg_wdata_i, // Wdata.
  output var  vectored_interrupt_sequencer_pkg::byte_t reg_rdata_o, // Rdata.
  input  wire logic                                  ei_i,         // Enable.
  input  wire logic                                  di_i,         // Disable.
  input  wire logic                                  instr_end_i,  // Insn end.
  input  wire logic                                  ret_i,        // Return.
  input  wire logic [3:0]                            hw_event_i,   // Timers.
  input  wire logic [7:0]                            sw_pend_i,    // Pendings.
  input  wire logic [15:0]                           pc_i,         // Core PC.
  input  wire vectored_interrupt_sequencer_pkg::byte_t flags_i,   // Flags.
  output logic                                       pc_load_o,    // Load PC.
  output logic [15:0]                                pc_o,         // New PC.
  output logic                                       flags_load_o, // Load fl.
  output vectored_interrupt_sequencer_pkg::byte_t    flags_o,      // New fl.
  output logic                                       stk_push_o,   // Push.
  output logic                                       stk_pop_o,    // Pop.
  output vectored_interrupt_sequencer_pkg::byte_t    stk_wdata_o,  // Push dat.
  input  wire vectored_interrupt_sequencer_pkg::byte_t stk_rdata_i, // Pop dat.
  output logic                                       pm_rd_o,      // Vec read.
  output vectored_interrupt_sequencer_pkg::byte_t    pm_addr_o,    // Vec addr.
  input  wire vectored_interrupt_sequencer_pkg::byte_t pm_rdata_i, // Vec dat.
  output logic                                       ack_o,        // Ack.
  output vectored_interrupt_sequencer_pkg::level_t   ack_level_o,  // Level.
  output logic                                       busy_o        // Stall.
);
  import vectored_interrupt_sequencer_pkg::*;
  // Lowest set bit of a request vector.
  function automatic level_t first_set(input logic [7:0] v);
    level_t r = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (v[i]) begin
        r = 3'(i);
      end
    end
    return r;
  endfunction : first_set
  // Vector slot: even, below 003CH, hardware source first.
  function automatic byte_t vec_addr(input level_t l, input logic sub);
    byte_t a;
    a = 8'h00;
    a[`VEC_LVL_LSB +: 3] = l;
    a[`VEC_SUB_BIT] = sub;
    return a;
  endfunction : vec_addr
  logic       rst_m_r;
  logic       rst_n_r;
  seq_state_e state_r;
  logic [15:0] fp_r;
  byte_t      mask_r;
  byte_t      prio_r;
  logic       gie_r;
  logic       fen_r;
  level_t     fsel_r;
  logic       sym7_r;
  logic [3:0] hw_pend_r;
  byte_t      status_r;
  byte_t      shadow_r;
  logic [15:0] save_pc_r;
  byte_t      save_fl_r;
  level_t     lvl_r;
  logic       sub_r;
  byte_t      vhi_r;
  byte_t      pch_r;
  byte_t      pfl_r;
  byte_t      cand;
  level_t     lvl_nxt;
  logic       sub_nxt;
  logic       take;
  logic       fast_nxt;
  logic       fast_ret;
  logic       wr_sym;
  // Reset release through two flip-flops.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_m_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_m_r <= 1'b1;
      rst_n_r <= rst_m_r;
    end
  end
  // Service decision from status, mask, global enable.
  always_comb begin
    cand     = status_r & mask_r;
    lvl_nxt  = first_set(cand);
    sub_nxt  = !(lvl_nxt < 3'(`HW_LEVELS) && hw_pend_r[lvl_nxt[1:0]]);
    take     = gie_r && (cand != 8'h00) && instr_end_i;
    fast_nxt = fen_r && (fsel_r == lvl_nxt);
    fast_ret = flags_i[`FAST_FLAG_BIT];
    wr_sym   = reg_wr_i && (reg_addr_i == `SYS_MODE_ADDR);
  end
  // Hidden pending bits of hardware-cleared sources; set wins over clear.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hw_pend_r <= 4'h0;
    end else begin
      for (int i = 0; i < `HW_LEVELS; i++) begin
        if (hw_event_i[i]) begin
          hw_pend_r[i] <= 1'b1;
        end else if (state_r == ST_IDLE && take && !ret_i &&
                     lvl_nxt == 3'(i) && !sub_nxt) begin
          hw_pend_r[i] <= 1'b0;
        end
      end
    end
  end
  // Level status tracks requests regardless of global enable.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      status_r <= `LVL_STATUS_RST;
    end else begin
      status_r <= sw_pend_i | {4'h0, hw_pend_r};
    end
  end
  // Mask and priority registers, written by software only.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      mask_r <= `LVL_MASK_RST;
      prio_r <= `LVL_PRIO_RST;
    end else if (reg_wr_i) begin
      if (reg_addr_i == `LVL_MASK_ADDR) begin
        mask_r <= reg_wdata_i;
      end
      if (reg_addr_i == `LVL_PRIO_ADDR) begin
        prio_r <= reg_wdata_i;
      end
    end
  end
  // Mode register fields; sequencer actions win over software.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      gie_r  <= 1'b0;
      fen_r  <= 1'b0;
      sym7_r <= 1'b0;
      fsel_r <= `FSEL_RST;
    end else begin
      if (wr_sym) begin
        fen_r  <= reg_wdata_i[`SYM_FEN_BIT];
        fsel_r <= reg_wdata_i[`SYM_FSEL_MSB:`SYM_FSEL_LSB];
        sym7_r <= reg_wdata_i[`SYM_TOP_BIT];
      end
      if (state_r == ST_IDLE && take && !ret_i) begin
        gie_r <= 1'b0;
      end else if (state_r == ST_RET ||
                   (state_r == ST_IDLE && ret_i && fast_ret)) begin
        gie_r <= 1'b1;
      end else if (ei_i) begin
        gie_r <= 1'b1;
      end else if (di_i) begin
        gie_r <= 1'b0;
      end else if (wr_sym) begin
        gie_r <= reg_wdata_i[`SYM_GIE_BIT];
      end
    end
  end
  // Fast pointer: byte writes, swapped with PC on fast entry and return.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fp_r <= `FP_RST;
    end else if (state_r == ST_FAST ||
                 (state_r == ST_IDLE && ret_i && fast_ret)) begin
      fp_r <= pc_i;
    end else if (reg_wr_i && reg_addr_i == `FP_HIGH_ADDR) begin
      fp_r[15:8] <= reg_wdata_i;
    end else if (reg_wr_i && reg_addr_i == `FP_LOW_ADDR) begin
      fp_r[7:0] <= reg_wdata_i;
    end
  end
  // Register read port, one cycle after the strobe.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        `FP_HIGH_ADDR:    reg_rdata_o <= fp_r[15:8];
        `FP_LOW_ADDR:     reg_rdata_o <= fp_r[7:0];
        `LVL_STATUS_ADDR: reg_rdata_o <= status_r;
        `LVL_MASK_ADDR:   reg_rdata_o <= mask_r;
        `SYS_MODE_ADDR:   reg_rdata_o <= {sym7_r, 2'b00, fsel_r,
                                          fen_r, gie_r};
        `LVL_PRIO_ADDR:   reg_rdata_o <= prio_r;
        default:          reg_rdata_o <= 8'h00;
      endcase
    end
  end
  // Entry and return sequencer.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      state_r <= ST_IDLE;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          if (ret_i) begin
            state_r <= fast_ret ? ST_WAIT : ST_PF;
          end else if (take) begin
            state_r <= fast_nxt ? ST_FAST : ST_PCL;
          end
        end
        ST_PCL:  state_r <= ST_PCH;
        ST_PCH:  state_r <= ST_FLG;
        ST_FLG:  state_r <= ST_VH;
        ST_VH:   state_r <= ST_VL;
        ST_VL:   state_r <= ST_JUMP;
        ST_JUMP: state_r <= ST_WAIT;
        ST_FAST: state_r <= ST_WAIT;
        ST_PF:   state_r <= ST_PPH;
        ST_PPH:  state_r <= ST_PPL;
        ST_PPL:  state_r <= ST_RET;
        ST_RET:  state_r <= ST_WAIT;
        ST_WAIT: state_r <= ST_IDLE;
        default: state_r <= ST_IDLE;
      endcase
    end
  end
  // Capture of context, chosen level and popped bytes.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      save_pc_r <= 16'h0000;
      save_fl_r <= 8'h00;
      lvl_r     <= 3'h0;
      sub_r     <= 1'b0;
      vhi_r     <= 8'h00;
      pch_r     <= 8'h00;
      pfl_r     <= 8'h00;
    end else begin
      if (state_r == ST_IDLE && take && !ret_i) begin
        save_pc_r <= pc_i;
        save_fl_r <= flags_i;
        lvl_r     <= lvl_nxt;
        sub_r     <= sub_nxt;
      end
      if (state_r == ST_VL) begin
        vhi_r <= pm_rdata_i;
      end
      if (state_r == ST_PPH) begin
        pfl_r <= stk_rdata_i;
      end
      if (state_r == ST_PPL) begin
        pch_r <= stk_rdata_i;
      end
    end
  end
  // Flags shadow for the fast path, fast flag kept clear inside it.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      shadow_r <= 8'h00;
    end else if (state_r == ST_FAST) begin
      shadow_r <= flags_i;
      shadow_r[`FAST_FLAG_BIT] <= 1'b0;
    end
  end
  // Stack port: pushes on normal entry, pops on normal return.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      stk_push_o  <= 1'b0;
      stk_pop_o   <= 1'b0;
      stk_wdata_o <= 8'h00;
    end else begin
      stk_push_o  <= (state_r == ST_PCL) || (state_r == ST_PCH) ||
                     (state_r == ST_FLG);
      stk_pop_o   <= (state_r == ST_PF) || (state_r == ST_PPH) ||
                     (state_r == ST_PPL);
      if (state_r == ST_PCL) begin
        stk_wdata_o <= save_pc_r[7:0];
      end else if (state_r == ST_PCH) begin
        stk_wdata_o <= save_pc_r[15:8];
      end else if (state_r == ST_FLG) begin
        stk_wdata_o <= save_fl_r;
      end
    end
  end
  // Vector fetch: high byte at the slot, low byte just above it.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pm_rd_o   <= 1'b0;
      pm_addr_o <= 8'h00;
    end else begin
      pm_rd_o <= (state_r == ST_FLG) || (state_r == ST_VH);
      if (state_r == ST_FLG) begin
        pm_addr_o <= vec_addr(lvl_r, sub_r);
      end else if (state_r == ST_VH) begin
        pm_addr_o <= vec_addr(lvl_r, sub_r) | 8'h01;
      end
    end
  end
  // PC and flag loads towards the core.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      pc_load_o    <= 1'b0;
      pc_o         <= 16'h0000;
      flags_load_o <= 1'b0;
      flags_o      <= 8'h00;
    end else begin
      pc_load_o    <= 1'b0;
      flags_load_o <= 1'b0;
      if (state_r == ST_JUMP) begin
        pc_load_o <= 1'b1;
        pc_o      <= {vhi_r, pm_rdata_i};
      end else if (state_r == ST_FAST) begin
        pc_load_o    <= 1'b1;
        pc_o         <= fp_r;
        flags_load_o <= 1'b1;
        flags_o      <= flags_i | 8'(1 << `FAST_FLAG_BIT);
      end else if (state_r == ST_IDLE && ret_i && fast_ret) begin
        pc_load_o    <= 1'b1;
        pc_o         <= fp_r;
        flags_load_o <= 1'b1;
        flags_o      <= shadow_r;
      end else if (state_r == ST_RET) begin
        pc_load_o    <= 1'b1;
        pc_o         <= {pch_r, stk_rdata_i};
        flags_load_o <= 1'b1;
        flags_o      <= pfl_r;
      end
    end
  end
  // Acknowledge pulse, level and core stall.
  always_ff @(posedge clk_sys_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      ack_o       <= 1'b0;
      ack_level_o <= 3'h0;
      busy_o      <= 1'b0;
    end else begin
      ack_o  <= (state_r == ST_IDLE) && take && !ret_i;
      busy_o <= (state_r == ST_IDLE) ? (ret_i || take) :
                (state_r != ST_WAIT);
      if (state_r == ST_IDLE && take && !ret_i) begin
        ack_level_o <= lvl_nxt;
      end
    end
  end
endmodule : vectored_interrupt_sequencer
`default_nettype wire

/* verilog/vectored_interrupt_sequencer_defines.svh */
`ifndef VECTORED_INTERRUPT_SEQUENCER_DEFINES_SVH
`define VECTORED_INTERRUPT_SEQUENCER_DEFINES_SVH
`define FP_HIGH_ADDR     8'hDA
`define FP_LOW_ADDR      8'hDB
`define LVL_STATUS_ADDR  8'hDC
`define LVL_MASK_ADDR    8'hDD
`define SYS_MODE_ADDR    8'hDE
`define LVL_PRIO_ADDR    8'hFF
`define LVL_STATUS_RST   8'h00
`define LVL_MASK_RST     8'h00
`define LVL_PRIO_RST     8'h00
`define FP_RST           16'h0000
`define SYM_GIE_BIT      0
`define SYM_FEN_BIT      1
`define SYM_FSEL_LSB     2
`define SYM_FSEL_MSB     4
`define SYM_TOP_BIT      7
`define FSEL_RST         3'h0
`define FAST_FLAG_BIT    1
`define HW_LEVELS        4
`define VEC_LVL_LSB      3
`define VEC_SUB_BIT      1
`endif

/* verilog/vectored_interrupt_sequencer_pkg.sv */
package vectored_interrupt_sequencer_pkg;
  // Sequencer states, one-hot.
  typedef enum logic [12:0] {
    ST_IDLE = 13'h0001,
    ST_PCL  = 13'h0002,
    ST_PCH  = 13'h0004,
    ST_FLG  = 13'h0008,
    ST_VH   = 13'h0010,
    ST_VL   = 13'h0020,
    ST_JUMP = 13'h0040,
    ST_FAST = 13'h0080,
    ST_PF   = 13'h0100,
    ST_PPH  = 13'h0200,
    ST_PPL  = 13'h0400,
    ST_RET  = 13'h0800,
    ST_WAIT = 13'h1000
  } seq_state_e;
  typedef logic [2:0] level_t;
  typedef logic [7:0] byte_t;
endpackage : vectored_interrupt_sequencer_pkg

/* test/vectored_interrupt_sequencer_properties.sv */
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_sequencer_properties (
  input wire logic        clk_sys_i,    // Clock.
  input wire logic        arst_n_i,     // Reset.
  input wire logic        instr_end_i,  // Insn end.
  input wire logic        ret_i,        // Return.
  input wire logic [15:0] pc_i,         // Core PC.
  input wire logic [7:0]  flags_i,      // Flags.
  input wire logic        pc_load_o,    // Load PC.
  input wire logic [15:0] pc_o,         // New PC.
  input wire logic        flags_load_o, // Load flags.
  input wire logic [7:0]  flags_o,      // New flags.
  input wire logic        stk_push_o,   // Push.
  input wire logic        stk_pop_o,    // Pop.
  input wire logic [7:0]  stk_wdata_o,  // Push data.
  input wire logic        pm_rd_o,      // Vector read.
  input wire logic [7:0]  pm_addr_o,    // Vector address.
  input wire logic [7:0]  pm_rdata_i,   // Vector data.
  input wire logic        ack_o,        // Acknowledge.
  input wire logic        busy_o        // Stall.
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!arst_n_i);
  // Entry and return sequencing as seen on the core-side ports.
  ack_cause_a: assert property (
    ack_o |-> $past(instr_end_i) && !$past(busy_o) && !$past(ret_i))
    else $error("acknowledge without an idle instruction end");
  ack_pulse_a: assert property (
    ack_o |=> !ack_o && busy_o)
    else $error("acknowledge not a single pulse under busy");
  push_order_a: assert property (
    ack_o ##1 stk_push_o |-> stk_push_o [*3] ##1 !stk_push_o)
    else $error("entry did not push exactly three bytes");
  push_data_a: assert property (
    ack_o ##1 stk_push_o |-> stk_wdata_o == pc_i[7:0]
      ##1 stk_wdata_o == pc_i[15:8] ##1 stk_wdata_o == flags_i)
    else $error("pushed bytes out of order");
  vec_addr_a: assert property (
    pm_rd_o && !pm_addr_o[0] |-> pm_addr_o < 8'h3C
      ##1 pm_rd_o && pm_addr_o == ($past(pm_addr_o) | 8'h01))
    else $error("vector fetch address wrong");
  vec_jump_a: assert property (
    pm_rd_o && pm_addr_o[0] |-> ##2 pc_load_o
      && pc_o == {$past(pm_rdata_i, 2), $past(pm_rdata_i)})
    else $error("jump target is not the fetched vector");
  fast_entry_a: assert property (
    ack_o ##1 !stk_push_o |-> pc_load_o && flags_load_o
      && flags_o == (flags_i | 8'h02))
    else $error("fast entry flags wrong");
  fast_ret_a: assert property (
    ret_i && !busy_o && flags_i[1] |=> pc_load_o && flags_load_o
      && !flags_o[1] && !stk_pop_o)
    else $error("fast return wrong");
  slow_ret_a: assert property (
    ret_i && !busy_o && !flags_i[1] |=> ##1 stk_pop_o [*3]
      ##1 (pc_load_o && flags_load_o))
    else $error("normal return wrong");
endmodule : vectored_interrupt_sequencer_properties
bind vectored_interrupt_sequencer vectored_interrupt_sequencer_properties u_prop (
  .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .instr_end_i(instr_end_i),
  .ret_i(ret_i), .pc_i(pc_i), .flags_i(flags_i), .pc_load_o(pc_load_o),
  .pc_o(pc_o), .flags_load_o(flags_load_o), .flags_o(flags_o),
  .stk_push_o(stk_push_o), .stk_pop_o(stk_pop_o), .stk_wdata_o(stk_wdata_o),
  .pm_rd_o(pm_rd_o), .pm_addr_o(pm_addr_o), .pm_rdata_i(pm_rdata_i),
  .ack_o(ack_o), .busy_o(busy_o));
`default_nettype wire

/* test/core_side_model.sv */
`timescale 1ns/1ps
`default_nettype none
module core_side_model (
  input  wire logic        clk_sys_i,    // Clock.
  input  wire logic        arst_n_i,     // Reset.
  input  wire logic        jump_i,       // Bench sets PC.
  input  wire logic [15:0] jump_pc_i,    // Bench PC.
  input  wire logic [7:0]  jump_flags_i, // Bench flags.
  input  wire logic        pc_load_i,    // Load PC.
  input  wire logic [15:0] pc_new_i,     // New PC.
  input  wire logic        flags_load_i, // Load flags.
  input  wire logic [7:0]  flags_new_i,  // New flags.
  input  wire logic        stk_push_i,   // Push.
  input  wire logic        stk_pop_i,    // Pop.
  input  wire logic [7:0]  stk_wdata_i,  // Push data.
  output logic      [7:0]  stk_rdata_o,  // Pop data.
  input  wire logic        pm_rd_i,      // Vector read.
  input  wire logic [7:0]  pm_addr_i,    // Vector address.
  output logic      [7:0]  pm_rdata_o,   // Vector data.
  output logic      [15:0] pc_o,         // Core PC.
  output logic      [7:0]  flags_o       // Core flags.
);
  logic [7:0] stk_mem [0:15];
  logic [3:0] sp_r;
  logic [7:0] junk_r;
  // The top byte stands while a pop is asked for; otherwise data toggles.
  always_comb begin
    stk_rdata_o = stk_pop_i ? stk_mem[sp_r - 4'h1] : junk_r;
  end
  // PC and flags follow the block's loads and stay put while it stalls.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_o <= 16'h0000;
      flags_o <= 8'h00;
    end else if (jump_i) begin
      pc_o <= jump_pc_i;
      flags_o <= jump_flags_i;
    end else begin
      if (pc_load_i) pc_o <= pc_new_i;
      if (flags_load_i) flags_o <= flags_new_i;
    end
  end
  // Stack is last in, first out; the pointer moves at the end of a pop.
  // Vector memory holds address xor A5; outside a read, data toggles.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_r <= 4'h0;
      junk_r <= 8'h00;
      pm_rdata_o <= 8'h00;
    end else begin
      junk_r <= ~junk_r;
      pm_rdata_o <= pm_rd_i ? (pm_addr_i ^ 8'hA5) : ~pm_rdata_o;
      if (stk_push_i) begin
        stk_mem[sp_r] <= stk_wdata_i;
        sp_r <= sp_r + 4'h1;
      end else if (stk_pop_i) begin
        sp_r <= sp_r - 4'h1;
      end
    end
  end
endmodule : core_side_model
`default_nettype wire

/* test/vectored_interrupt_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module vectored_interrupt_sequencer_tb;
  import vectored_interrupt_sequencer_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        arst_n_i = 1'b0;
  logic [7:0]  reg_addr = 8'h00;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  byte_t       reg_wdata = 8'h00;
  logic [3:0]  ctl = 4'h0;       // Return, insn end, disable, enable.
  logic [3:0]  hw_event = 4'h0;
  logic [7:0]  sw_pend = 8'h00;
  logic        jump = 1'b0;
  logic [15:0] jump_pc = 16'h0000;
  byte_t       jump_flags = 8'h00;
  logic [15:0] pc, pc_new;
  byte_t       reg_rdata, flags, flags_new, stk_wdata, stk_rdata;
  byte_t       pm_addr, pm_rdata;
  logic        pc_load, flags_load, stk_push, stk_pop, pm_rd, ack, busy;
  level_t      ack_level, ack_lvl;
  int          err_total = 0;
  int          compares = 0;
  int          acks = 0;
  int          seed = 32'h62d1;
  always #5 clk_sys_i = ~clk_sys_i;
  // Block under test and the core it serves.
  vectored_interrupt_sequencer DUT (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr),
    .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_wdata_i(reg_wdata),
    .reg_rdata_o(reg_rdata), .ei_i(ctl[0]), .di_i(ctl[1]),
    .instr_end_i(ctl[2]), .ret_i(ctl[3]), .hw_event_i(hw_event),
    .sw_pend_i(sw_pend), .pc_i(pc), .flags_i(flags), .pc_load_o(pc_load),
    .pc_o(pc_new), .flags_load_o(flags_load), .flags_o(flags_new),
    .stk_push_o(stk_push), .stk_pop_o(stk_pop), .stk_wdata_o(stk_wdata),
    .stk_rdata_i(stk_rdata), .pm_rd_o(pm_rd), .pm_addr_o(pm_addr),
    .pm_rdata_i(pm_rdata), .ack_o(ack), .ack_level_o(ack_level),
    .busy_o(busy));
  core_side_model core (
    .clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .jump_i(jump),
    .jump_pc_i(jump_pc), .jump_flags_i(jump_flags), .pc_load_i(pc_load),
    .pc_new_i(pc_new), .flags_load_i(flags_load), .flags_new_i(flags_new),
    .stk_push_i(stk_push), .stk_pop_i(stk_pop), .stk_wdata_i(stk_wdata),
    .stk_rdata_o(stk_rdata), .pm_rd_i(pm_rd), .pm_addr_i(pm_addr),
    .pm_rdata_o(pm_rdata), .pc_o(pc), .flags_o(flags));
  // Counts acknowledges and keeps the latest level.
  always @(posedge clk_sys_i) begin
    if (ack === 1'b1) begin
      acks++;
      ack_lvl = ack_level;
    end
  end
  function automatic logic [15:0] vec_exp(input logic [7:0] slot);
    return {slot ^ 8'hA5, (slot | 8'h01) ^ 8'hA5};
  endfunction : vec_exp
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic wr(input logic [7:0] a, input byte_t d);
    @(negedge clk_sys_i);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys_i);
    reg_wr = 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output byte_t d);
    @(negedge clk_sys_i);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk_sys_i);
    reg_rd = 1'b0;
    d = reg_rdata;
  endtask : rd
  task automatic strobe(input int k);
    @(negedge clk_sys_i);
    ctl[k] = 1'b1;
    @(negedge clk_sys_i);
    ctl[k] = 1'b0;
  endtask : strobe
  task automatic idle;
    int n;
    n = 0;
    repeat (3) @(negedge clk_sys_i);
    while (busy !== 1'b0 && n < 60) begin
      @(negedge clk_sys_i);
      n++;
    end
  endtask : idle
  // One full service of level l: entry, checks, then return.
  task automatic svc(input level_t l, input logic hw, input logic fast);
    logic [15:0] old_pc, ptr;
    byte_t       old_fl, d, h;
    old_pc = $random(seed);
    old_fl = $random(seed) & 8'hFD;
    ptr = $random(seed);
    @(negedge clk_sys_i);
    jump = 1'b1;
    jump_pc = old_pc;
    jump_flags = old_fl;
    @(negedge clk_sys_i);
    jump = 1'b0;
    wr(8'hDA, ptr[15:8]);
    wr(8'hDB, ptr[7:0]);
    wr(8'hDE, {3'b000, l, 2'b01});
    wr(8'hDE, {3'b000, l, fast, 1'b1});
    if (hw) hw_event[l[1:0]] = 1'b1;
    else sw_pend[l] = 1'b1;
    @(negedge clk_sys_i);
    hw_event = 4'h0;
    repeat (2) @(negedge clk_sys_i);
    rd(8'hDC, d);
    check(d[l], 1'b1);
    acks = 0;
    strobe(2);
    idle;
    check(acks[15:0], 16'h0001);
    check(ack_lvl, l);
    if (fast) begin
      check(pc_new, ptr);
      check(flags_new, old_fl | 8'h02);
      rd(8'hDA, h);
      rd(8'hDB, d);
      check({h, d}, old_pc);
    end else begin
      check(pc_new, vec_exp({2'b00, l, 1'b0, ~hw, 1'b0}));
    end
    rd(8'hDE, d);
    check(d[0], 1'b0);
    strobe(2);
    idle;
    check(acks[15:0], 16'h0001);
    if (!hw) sw_pend[l] = 1'b0;
    repeat (2) @(negedge clk_sys_i);
    rd(8'hDC, d);
    check(d[l], sw_pend[l]);
    strobe(3);
    idle;
    check(pc_new, old_pc);
    check(flags_new, old_fl);
    rd(8'hDE, d);
    check(d[0], 1'b1);
  endtask : svc
  // Watchdog: the whole run needs well under this span.
  initial begin
    repeat (30000) @(posedge clk_sys_i);
    err_total++;
    give_verdict;
  end
  // Main sequence.
  initial begin
    byte_t d, m;
    int    r;
    repeat (20) @(negedge clk_sys_i);
    arst_n_i = 1'b1;
    repeat (3) @(negedge clk_sys_i);
    rd(8'hDC, d);
    check(d, 8'h00);
    rd(8'hDE, d);
    check(d & 8'hE3, 8'h00);
    wr(8'hDC, 8'hFF);
    rd(8'hDC, d);
    check(d, 8'h00);
    rd(8'h10, d);
    check(d, 8'h00);
    $display("test reset_values done");
    wr(8'hDD, 8'hFB);
    strobe(1);
    sw_pend = 8'h24;
    repeat (2) @(negedge clk_sys_i);
    rd(8'hDC, d);
    check(d, 8'h24);
    acks = 0;
    strobe(2);
    idle;
    check(acks[15:0], 16'h0000);
    strobe(0);
    strobe(2);
    idle;
    check(ack_lvl, 3'd5);
    rd(8'hDD, m);
    wr(8'hDD, 8'h01);
    strobe(0);
    sw_pend[0] = 1'b1;
    repeat (2) @(negedge clk_sys_i);
    strobe(2);
    idle;
    check(ack_lvl, 3'd0);
    check(pc_new, vec_exp(8'h02));
    sw_pend[0] = 1'b0;
    strobe(3);
    idle;
    check(pc_new, vec_exp(8'h2A));
    wr(8'hDD, m);
    sw_pend = 8'h00;
    strobe(3);
    idle;
    check(pc_new, 16'h0000);
    wr(8'hDD, 8'hFF);
    $display("test mask_priority done");
    sw_pend[1] = 1'b1;
    svc(3'd1, 1'b1, 1'b0);
    svc(3'd1, 1'b0, 1'b0);
    for (int l = 0; l < 8; l++) begin
      r = $random(seed);
      svc(l[2:0], l < 4 && r[0], 1'b0);
      svc(l[2:0], l < 4, 1'b1);
    end
    repeat (8) begin
      r = $random(seed);
      svc(r[2:0], !r[2] && r[3], r[4]);
    end
    $display("test services done");
    give_verdict;
  end
endmodule : vectored_interrupt_sequencer_tb
`default_nettype wire
